// *** verilog/tip_pkg.sv ***
// constants and carrier types of the touch controller i2c target port
// assumes one 40 MHz system clock, bus pins synchronised inside the block
`default_nettype none
package tip_pkg;

  // ************************************************************
  // bus addresses, 8-bit form with direction bit in bit 0
  // ************************************************************
  localparam logic [7:0] TIP_ADDR_PAIR_A = 8'hBA; // selected by interrupt pin low
  localparam logic [7:0] TIP_ADDR_PAIR_B = 8'h28; // selected by interrupt pin high
  localparam int         TIP_DIR_BIT     = 0;
  localparam logic       TIP_DIR_WRITE   = 1'b0;
  localparam logic       TIP_DIR_READ    = 1'b1;

  // ************************************************************
  // framing and timing
  // ************************************************************
  localparam logic [3:0] TIP_BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] TIP_LAST_TX_BIT   = 3'h7;
  localparam int         TIP_SYS_CLK_HZ    = 40_000_000;
  localparam int         TIP_BUS_MAX_BPS   = 400_000;
  localparam int         TIP_SYS_PER_BIT   = TIP_SYS_CLK_HZ / TIP_BUS_MAX_BPS;
  localparam logic [1:0] TIP_STRAP_CYCLES  = 2'h3; // sync depth plus one
  localparam logic [15:0] TIP_PTR_RESET    = 16'h0000;
  localparam int         TIP_FIFO_DEPTH    = 8;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    TIP_ST_IDLE,
    TIP_ST_RX,
    TIP_ST_ACK,
    TIP_ST_TX,
    TIP_ST_HACK
  } tip_state_t;

  typedef enum logic [1:0] {
    TIP_BY_ADDR,
    TIP_BY_PTR_HI,
    TIP_BY_PTR_LO,
    TIP_BY_DATA
  } tip_byte_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } tip_wr_t;

endpackage
`default_nettype wire

// *** verilog/tip_sync.sv ***
// two-flop synchroniser for a group of asynchronous pin levels
// assumes inputs are plain levels; outputs are only valid two edges later
`timescale 1ns/1ps
`default_nettype none
module tip_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk, // system clock
  input  wire logic             reset,   // async, active high
  input  wire logic [WIDTH-1:0] pin_in,  // asynchronous levels
  output var  logic [WIDTH-1:0] pin_sync // synchronised levels
);
  logic [WIDTH-1:0] meta;

  // reset to ones: idle bus lines float high
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta     <= '1;
      pin_sync <= '1;
    end else begin
      meta     <= pin_in;
      pin_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// *** verilog/tip_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
// assumes one clock; depth is a power of two
`timescale 1ns/1ps
`default_nettype none
module tip_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,   // system clock
  input  wire logic             reset,     // async, active high
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // not full
  input  wire logic [WIDTH-1:0] in_data,   // write word
  output logic                  out_valid, // not empty
  input  wire logic             out_ready, // drain accepts
  output logic      [WIDTH-1:0] out_data   // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  assign in_ready  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/tip_target.sv ***
// touch controller i2c target port: address match, pointer, burst write/read
// assumes open-drain pins resolved outside; register store sits on the user side
//
// Overview of operation
// RULE_01 - device is target only, never starts transfers
// RULE_02 - host clocks bus at most 400 kbps
// RULE_03 - answer at address pair chosen by strap
// RULE_04 - start is sda falling while scl high
// RULE_05 - on match drive ack low ninth clock
// RULE_06 - mismatch: no ack, idle until next start
// RULE_07 - each byte is nine clocks, eight plus ack
// RULE_08 - sda sampled high phase, stable while high
// RULE_09 - stop is sda rising while scl high
// RULE_10 - write: address, 16-bit pointer, data bytes
// RULE_11 - pointer increments after each written byte
// RULE_12 - read: pointer write, repeated start, read address
// RULE_13 - host acks reads, nack then stop ends
// RULE_14 - pointer advances after each sent byte
// RULE_15 - latch address pair from interrupt pin at reset
// RULE_16 - release sda whenever not driving a bit
`timescale 1ns/1ps
`default_nettype none
module tip_target
  import tip_pkg::*;
#(
  parameter int FIFO_DEPTH = tip_pkg::TIP_FIFO_DEPTH
) (
  input  wire logic             sys_clk,   // 40 MHz system clock
  input  wire logic             reset,     // async, active high
  input  wire logic             scl_in,    // bus clock pin level
  input  wire logic             sda_in,    // bus data pin level
  output logic                  sda_out,   // bus data drive value
  output logic                  sda_oe,    // bus data drive enable
  input  wire logic             int_in,    // interrupt pin level
  output logic                  int_out,   // interrupt pin drive value
  output logic                  int_oe,    // interrupt pin drive enable
  input  wire logic             touch_irq, // touch event level to pin
  output tip_pkg::tip_wr_t      wr_word,   // written address and byte
  output logic                  wr_valid,  // written word available
  input  wire logic             wr_ready,  // store takes written word
  output logic           [15:0] rd_addr,   // address of byte to send
  input  wire logic       [7:0] rd_data,   // byte at rd_addr
  output logic                  addr_sel   // latched address pair, 1 = 0x28
);
  import tip_pkg::*;

  // ************************************************************
  // pin synchronisation and bus events
  // ************************************************************
  logic [2:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       int_s;
  logic       scl_d;
  logic       sda_d;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;

  tip_sync #(.WIDTH(3)) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .pin_in   ({int_in, sda_in, scl_in}),
    .pin_sync (pins_s)
  );
  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign int_s = pins_s[2];

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s; // RULE_04
  assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s; // RULE_09

  // ************************************************************
  // address strap
  // ************************************************************
  logic [1:0] strap_cnt;
  logic       strap_done;

  // caught after release, once the synchroniser holds the real level
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
      addr_sel   <= 1'b0;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == TIP_STRAP_CYCLES) begin
        strap_done <= 1'b1;
        addr_sel   <= int_s; // RULE_15
      end
    end
  end

  // pin stays released until the strap is latched
  assign int_oe  = strap_done; // RULE_15
  assign int_out = touch_irq;

  // ************************************************************
  // byte engine
  // ************************************************************
  tip_state_t state;
  tip_byte_t  kind;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic       dir_read;
  logic [15:0] ptr;
  logic       host_ack;
  logic [7:0] own_addr;
  logic       addr_hit;
  logic       byte_done;
  logic       push;
  logic       load_tx;
  logic       fifo_in_ready;

  assign own_addr  = addr_sel ? TIP_ADDR_PAIR_B : TIP_ADDR_PAIR_A; // RULE_03
  assign addr_hit  = (shift[7:1] == own_addr[7:1]); // RULE_03
  assign byte_done = (state == TIP_ST_RX) && scl_fall && (bit_cnt == TIP_BITS_PER_BYTE);
  // no clock stretching: a full fifo answers the byte with nack
  assign push      = byte_done && (kind == TIP_BY_DATA) && fifo_in_ready;
  assign load_tx   = scl_fall && dir_read &&
                     (((state == TIP_ST_ACK) && (kind == TIP_BY_ADDR)) ||
                      ((state == TIP_ST_HACK) && host_ack));
  assign rd_addr   = ptr;

  // starts and stops win over any bit in flight
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state    <= TIP_ST_IDLE;
      kind     <= TIP_BY_ADDR;
      bit_cnt  <= 4'h0;
      shift    <= 8'h00;
      dir_read <= 1'b0;
      host_ack <= 1'b0;
    end else if (bus_start) begin
      state   <= TIP_ST_RX; // RULE_04
      kind    <= TIP_BY_ADDR;
      bit_cnt <= 4'h0;
    end else if (bus_stop) begin
      state <= TIP_ST_IDLE; // RULE_09
    end else begin
      case (state)
        TIP_ST_IDLE: begin
          bit_cnt <= 4'h0;
        end
        TIP_ST_RX: begin
          if (scl_rise && bit_cnt < TIP_BITS_PER_BYTE) begin
            shift   <= {shift[6:0], sda_s}; // RULE_08
            bit_cnt <= bit_cnt + 4'h1; // RULE_07
          end else if (byte_done) begin
            bit_cnt <= 4'h0;
            case (kind)
              TIP_BY_ADDR: begin
                if (addr_hit) begin
                  dir_read <= shift[TIP_DIR_BIT];
                  state    <= TIP_ST_ACK; // RULE_05
                end else begin
                  state <= TIP_ST_IDLE; // RULE_06
                end
              end
              TIP_BY_DATA: begin
                state <= fifo_in_ready ? TIP_ST_ACK : TIP_ST_IDLE;
              end
              default: begin
                state <= TIP_ST_ACK;
              end
            endcase
          end
        end
        TIP_ST_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (load_tx) begin
              shift <= rd_data; // RULE_12
              state <= TIP_ST_TX;
            end else begin
              state <= TIP_ST_RX; // RULE_16
              case (kind)
                TIP_BY_ADDR:   kind <= TIP_BY_PTR_HI; // RULE_10
                TIP_BY_PTR_HI: kind <= TIP_BY_PTR_LO;
                default:       kind <= TIP_BY_DATA;
              endcase
            end
          end
        end
        TIP_ST_TX: begin
          if (scl_fall) begin
            shift <= {shift[6:0], 1'b0};
            if (bit_cnt[2:0] == TIP_LAST_TX_BIT) begin
              state <= TIP_ST_HACK; // RULE_16
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        TIP_ST_HACK: begin
          if (scl_rise) begin
            host_ack <= ~sda_s;
          end else if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (host_ack) begin
              shift <= rd_data; // RULE_13
              state <= TIP_ST_TX;
            end else begin
              state <= TIP_ST_IDLE; // RULE_13
            end
          end
        end
        default: begin
          state <= TIP_ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // register pointer
  // ************************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ptr <= TIP_PTR_RESET;
    end else if (byte_done && kind == TIP_BY_PTR_HI) begin
      ptr[15:8] <= shift; // RULE_10
    end else if (byte_done && kind == TIP_BY_PTR_LO) begin
      ptr[7:0] <= shift;
    end else if (push) begin
      ptr <= ptr + 16'h0001; // RULE_11
    end else if (load_tx) begin
      ptr <= ptr + 16'h0001; // RULE_14
    end
  end

  // ************************************************************
  // pin drive: only pulls low, released otherwise
  // ************************************************************
  assign sda_out = 1'b0;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sda_oe <= 1'b0;
    end else begin
      // changes only after scl low, so data holds through the high phase
      sda_oe <= (state == TIP_ST_ACK) ||
                ((state == TIP_ST_TX) && !shift[7]); // RULE_01 RULE_16
    end
  end

  // ************************************************************
  // write buffer
  // ************************************************************
  tip_wr_t fifo_in;
  assign fifo_in.addr = ptr;
  assign fifo_in.data = shift;

  tip_fifo #(
    .WIDTH ($bits(tip_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_word)
  );

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  start_to_addr_a: assert property ( // RULE_04
    bus_start |=> state == TIP_ST_RX && kind == TIP_BY_ADDR && bit_cnt == 4'h0
  ) else $error("start not taken");
  stop_release_a: assert property ( // RULE_09
    bus_stop && !bus_start |=> state == TIP_ST_IDLE ##1 !sda_oe
  ) else $error("stop did not release");
  ack_low_a: assert property ( // RULE_05
    byte_done && kind == TIP_BY_ADDR && addr_hit && !bus_start && !bus_stop
      |=> ##1 sda_oe
  ) else $error("no address ack");
  miss_idle_a: assert property ( // RULE_06
    byte_done && kind == TIP_BY_ADDR && !addr_hit && !bus_start && !bus_stop
      |=> state == TIP_ST_IDLE ##1 !sda_oe
  ) else $error("mismatch acked");
  nine_clock_a: assert property ( // RULE_07
    state == TIP_ST_RX |-> bit_cnt <= TIP_BITS_PER_BYTE
  ) else $error("byte overrun");
  high_stable_a: assert property ( // RULE_08
    scl_s && $past(scl_s) && $past(scl_s, 2) |-> $stable(sda_oe)
  ) else $error("sda moved while scl high");
  wr_inc_a: assert property ( // RULE_11
    push |=> ptr == $past(ptr) + 16'h0001
  ) else $error("write pointer stuck");
  rd_inc_a: assert property ( // RULE_14
    load_tx && !bus_start && !bus_stop
      |=> ptr == $past(ptr) + 16'h0001 && shift == $past(rd_data)
  ) else $error("read pointer stuck");
  drive_owned_a: assert property ( // RULE_16
    sda_oe |-> $past(state) == TIP_ST_ACK || $past(state) == TIP_ST_TX
  ) else $error("sda driven out of turn");
  strap_latch_a: assert property ( // RULE_15
    $rose(strap_done) |-> addr_sel == $past(int_s) && int_oe
  ) else $error("strap not latched");

  write_burst_c: cover property (push ##[1:1000] push);
  read_burst_c: cover property (load_tx ##[1:1000] load_tx);
  miss_c: cover property (byte_done && kind == TIP_BY_ADDR && !addr_hit);
  fifo_full_c: cover property (byte_done && kind == TIP_BY_DATA && !fifo_in_ready);
endmodule
`default_nettype wire

// *** sim/tip_host_model.sv ***
// i2c host model: the bus master that clocks scl and pulls sda low
// assumes sda is resolved outside with a pull-up and scl has no other driver
`timescale 1ns/1ps
`default_nettype none
module tip_host_model #(
  parameter int HALF = 50 // half bit in sys_clk, 100 per bit is 400 kbps
) (
  input  wire logic sys_clk,  // system clock
  input  wire logic sda,      // resolved data line
  output var  logic scl,      // bus clock, high while idle
  output var  logic sda_pull  // high pulls sda low
);
  // ************************************************************
  // bus phases
  // ************************************************************
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_q(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // also serves as repeated start after a low scl phase
  task automatic start();
    wait_q(HALF / 2);
    sda_pull <= 1'b0;
    wait_q(HALF / 2);
    scl <= 1'b1;
    wait_q(HALF);
    sda_pull <= 1'b1;
    wait_q(HALF);
    scl <= 1'b0;
  endtask

  task automatic stop();
    wait_q(HALF / 2);
    sda_pull <= 1'b1;
    wait_q(HALF / 2);
    scl <= 1'b1;
    wait_q(HALF);
    sda_pull <= 1'b0;
    wait_q(HALF);
  endtask

  // data moves a quarter bit after the fall, never while scl is high
  task automatic bit_io(input logic b, output logic r);
    wait_q(HALF / 2);
    sda_pull <= ~b;
    wait_q(HALF / 2);
    scl <= 1'b1;
    wait_q(HALF);
    r = sda;
    scl <= 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule
`default_nettype wire

// *** sim/touch_i2c_target_port_tb.sv ***
// bench for the touch controller i2c target port
// assumes tip_host_model as bus master; register store modelled here
`timescale 1ns/1ps
`default_nettype none
module touch_i2c_target_port_tb;
  import tip_pkg::*;
  logic        sys_clk, reset, int_strap, touch_irq, wr_ready, drain_en;
  logic        scl, sda, host_pull, sda_out, sda_oe, int_out, int_oe, int_pin;
  logic        wr_valid, addr_sel;
  tip_wr_t     wr_word;
  logic [15:0] rd_addr;
  logic [7:0]  rd_data;
  int          bad_count, comparisons;
  logic [23:0] exp_q[$];
  logic [7:0]  rd_seen;

  // ************************************************************
  // wiring and store model
  // ************************************************************
  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  assign rd_data = mem(rd_addr);
  assign sda = ~(host_pull | (sda_oe & ~sda_out));
  assign int_pin = int_oe ? int_out : int_strap;

  tip_target dut (.sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .int_in(int_pin), .int_out(int_out),
    .int_oe(int_oe), .touch_irq(touch_irq), .wr_word(wr_word), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_addr(rd_addr), .rd_data(rd_data), .addr_sel(addr_sel));
  tip_host_model host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_pull(host_pull));

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // pop judged half a cycle ahead, where the fifo outputs are settled
  always @(negedge sys_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      if (exp_q.size() == 0) check("wr_word", wr_word, 24'hXXXXXX);
      else check("wr_word", wr_word, exp_q.pop_front());
    end
  end

  // random drain keeps the fifo filling and emptying at odd moments
  always @(posedge sys_clk) begin
    wr_ready <= drain_en & 1'($urandom);
    touch_irq <= 1'($urandom);
  end

  // ************************************************************
  // sequences
  // ************************************************************
  task automatic do_reset(input logic strap);
    reset <= 1'b1;
    int_strap <= strap;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (10) @(posedge sys_clk);
    check("addr_sel", addr_sel, strap);
    check("int_oe", int_oe, 1'b1);
    check("int_pin", int_pin, touch_irq);
  endtask

  task automatic send(input logic [7:0] d, input logic exp, input string name);
    logic a;
    host.wbyte(d, a);
    check(name, a, exp);
  endtask

  task automatic wr_seq(input logic [7:0] adr, input logic hit, input logic [15:0] p,
                        input int n, input int lim);
    logic [7:0] d;
    logic       ok;
    host.start();
    send(adr, hit, "addr_ack");
    send(p[15:8], hit, "ptr_hi_ack");
    send(p[7:0], hit, "ptr_lo_ack");
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      ok = hit && (i < lim);
      if (ok) exp_q.push_back({p, d});
      if (ok) p++;
      send(d, ok, "data_ack");
    end
    host.stop();
  endtask

  task automatic rd_seq(input logic [15:0] p, input int n);
    logic [7:0] d;
    host.start();
    send(TIP_ADDR_PAIR_A, 1'b1, "addr_ack");
    send(p[15:8], 1'b1, "ptr_hi_ack");
    send(p[7:0], 1'b1, "ptr_lo_ack");
    host.start();
    send(TIP_ADDR_PAIR_A | 8'h01, 1'b1, "rd_addr_ack");
    for (int i = 0; i < n; i++) begin
      host.rbyte(i < n - 1, d);
      check("rd_byte", d, mem(p + 16'(i)));
    end
    host.stop();
    repeat (8) @(posedge sys_clk);
    check("sda_oe", sda_oe, 1'b0);
    check("rd_addr", rd_addr, p + 16'(n));
  endtask

  initial begin
    reset = 1'b1;
    int_strap = 1'b0;
    drain_en = 1'b1;
    bad_count = 0;
    comparisons = 0;
    void'($urandom(32'h9968));
    do_reset(1'b0);
    wr_seq(TIP_ADDR_PAIR_A, 1'b1, 16'hFFFE, 3, 3);
    check("rd_addr", rd_addr, 16'h0001);
    wr_seq(8'h50, 1'b0, 16'h1234, 2, 2);
    check("rd_addr", rd_addr, 16'h0001);
    rd_seq(16'h00F0, 3);
    drain_en <= 1'b0;
    wr_seq(TIP_ADDR_PAIR_A, 1'b1, 16'h0200, 9, 8);
    check("rd_addr", rd_addr, 16'h0208);
    check("wr_valid", wr_valid, 1'b1);
    drain_en <= 1'b1;
    for (int i = 0; i < 300 && wr_valid !== 1'b0; i++) @(posedge sys_clk);
    check("left_words", 24'(exp_q.size()), 24'h000000);
    do_reset(1'b1);
    wr_seq(TIP_ADDR_PAIR_B, 1'b1, 16'h0010, 2, 2);
    wr_seq(TIP_ADDR_PAIR_A, 1'b0, 16'h0010, 1, 1);
    check("rd_addr", rd_addr, 16'h0012);
    // read at the second pair, straight from the current pointer
    host.start();
    send(TIP_ADDR_PAIR_B | 8'h01, 1'b1, "rd_addr_ack");
    host.rbyte(1'b0, rd_seen);
    check("rd_byte", rd_seen, mem(16'h0012));
    host.stop();
    repeat (8) @(posedge sys_clk);
    check("sda_oe", sda_oe, 1'b0);
    check("rd_addr", rd_addr, 16'h0013);
    repeat (300) @(posedge sys_clk);
    conclude();
  end

  // whole run is near 40000 cycles
  initial begin
    repeat (80000) @(posedge sys_clk);
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
